// >>> ilc_pkg.sv
// Constants, register map and carrier types of the two-level interrupt controller
// Summary of operation
// - Source condition sets its pending flag
// - Flag sets regardless of any enable
// - Enabled pending flag raises a request
// - Finish instruction, then long call vector
// - Service ends with return; core resumes program
// - Disabled flags are ignored, no vectoring
// - One enable bit per source, two registers
// - Source enables count only with global gate
// - Global gate low blocks every request
// - Self-clearing flags drop when vectoring
// - After return, one instruction then re-enter
// - Two priority levels, assignable per source
// - High preempts low; high never preempted
// - High level first, then fixed source order
// - Software-set flag vectors like hardware one
// - Requests sampled and decoded every clock
package ilc_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int N_SRC      = 15;  // Interrupt sources
    localparam int AW         = 3;   // Register address width
    localparam int DW         = 8;   // Register data width
    localparam int IDX_W      = 4;   // Source index width
    localparam int VEC_W      = 16;  // Vector address width
    localparam int N_EXT      = 2;   // External interrupt pins
    localparam int PRI_SRCS   = 7;   // Sources held in the primary registers
    localparam int PEND_SPLIT = 8;   // Sources held in the low pending register
    localparam int GATE_BIT   = 7;   // Global gate position in primary mask

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [AW-1:0] ADDR_MASK_PRI = 3'h0;
    localparam logic [AW-1:0] ADDR_MASK_EXT = 3'h1;
    localparam logic [AW-1:0] ADDR_PRIO_PRI = 3'h2;
    localparam logic [AW-1:0] ADDR_PRIO_EXT = 3'h3;
    localparam logic [AW-1:0] ADDR_PEND_LO  = 3'h4;
    localparam logic [AW-1:0] ADDR_PEND_HI  = 3'h5;
    localparam logic [AW-1:0] ADDR_STATUS   = 3'h6;

    // ************************************************************
    // Reset values and vectors
    // ************************************************************
    localparam logic [N_SRC-1:0] RST_SRC_BITS = 15'h0000;
    localparam logic [N_SRC-1:0] HW_CLEAR_SRCS = 15'h000f;
    localparam logic [VEC_W-1:0] VEC_BASE     = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STEP     = 16'h0008;
    localparam int               EXT0_IDX     = 0;
    localparam int               EXT1_IDX     = 2;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } ilc_bus_t;

    typedef struct packed {
        logic instrEnd;  // An instruction completes this cycle
        logic retiEnd;   // That instruction is return_from_interrupt
    } ilc_core_t;

    typedef struct packed {
        logic             start;   // One-cycle long_call request
        logic             high;    // Level of the routine entered
        logic [VEC_W-1:0] vector;  // Fixed vector of the source
    } ilc_call_t;

endpackage

// >>> ilc_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
module ilc_sync
    import ilc_pkg::*;
#(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ilc_sync_state_t;

    ilc_sync_state_t st;
    ilc_sync_state_t next_st;

    // Shift the pins through two stages; pins idle high
    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.s2;

endmodule

// >>> ilc_pick.sv
// Fixed-order picker: lowest set index wins
module ilc_pick
    import ilc_pkg::*;
#(
    parameter int N = N_SRC
) (
    input  wire logic [N-1:0]     req,
    output logic                  found,
    output logic      [IDX_W-1:0] idx
);

    // Scan from the top so the lowest index is left standing
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = IDX_W'(i);
            end
        end
    end

endmodule

// >>> ilc_controller.sv
// Two-level interrupt controller: flags, masks, arbitration and vectoring
module ilc_controller
    import ilc_pkg::*;
#(
    parameter logic [N_SRC-1:0] HW_CLEAR = HW_CLEAR_SRCS
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire ilc_bus_t          bus,
    output logic      [DW-1:0]     rdata,
    input  wire logic [N_SRC-1:0]  srcEvent,
    input  wire logic [N_EXT-1:0]  extIrq_n,
    input  wire ilc_core_t         core,
    output ilc_call_t              call,
    output logic                   irqRequest,
    output logic      [1:0]        inService
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic              gate;
        logic [N_SRC-1:0]  en;
        logic [N_SRC-1:0]  prio;
        logic [N_SRC-1:0]  pend;
        logic [N_EXT-1:0]  extPrev;
        logic              irqRequest;
        logic              activeHigh;
        logic              activeLow;
        logic              blockOne;
        logic              callStart;
        logic              callHigh;
        logic [VEC_W-1:0]  callVector;
        logic [DW-1:0]     rdata;
    } ilc_ctl_state_t;

    ilc_ctl_state_t    st;
    ilc_ctl_state_t    next_st;
    logic [N_EXT-1:0]  extSync;
    logic [N_SRC-1:0]  evt;
    logic [N_SRC-1:0]  elig;
    logic [N_SRC-1:0]  hiSet;
    logic [N_SRC-1:0]  loSet;
    logic              hiFound;
    logic              loFound;
    logic [IDX_W-1:0]  hiIdx;
    logic [IDX_W-1:0]  loIdx;
    logic [IDX_W-1:0]  takeIdx;
    logic              take;

    // ************************************************************
    // External pins and source events
    // ************************************************************
    ilc_sync #(
        .W (N_EXT)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   (extIrq_n),
        .dout  (extSync)
    );

    // Falling edge on a synchronised pin is a valid condition
    always_comb begin
        evt = srcEvent;
        evt[EXT0_IDX] = srcEvent[EXT0_IDX] | (st.extPrev[0] & ~extSync[0]);
        evt[EXT1_IDX] = srcEvent[EXT1_IDX] | (st.extPrev[1] & ~extSync[1]);
    end

    // ************************************************************
    // Arbitration
    // ************************************************************
    // Enabled flags, gated by the global gate, split by level
    assign elig  = st.pend & st.en & {N_SRC{st.gate}};
    assign hiSet = elig & st.prio;
    assign loSet = elig & ~st.prio;

    ilc_pick #(
        .N (N_SRC)
    ) u_pick_high (
        .req   (hiSet),
        .found (hiFound),
        .idx   (hiIdx)
    );

    ilc_pick #(
        .N (N_SRC)
    ) u_pick_low (
        .req   (loSet),
        .found (loFound),
        .idx   (loIdx)
    );

    // Vector at an instruction boundary, never on the return boundary itself
    always_comb begin
        take = core.instrEnd && !core.retiEnd && !st.activeHigh
            && (hiFound || (loFound && !st.activeLow));
        takeIdx = hiFound ? hiIdx : loIdx;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st           = st;
        next_st.callStart = 1'b0;
        next_st.rdata     = 8'h00;
        next_st.extPrev   = extSync;
        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                ADDR_MASK_PRI: begin
                    next_st.gate = bus.wdata[GATE_BIT];
                    next_st.en[PRI_SRCS-1:0] = bus.wdata[PRI_SRCS-1:0];
                end
                ADDR_MASK_EXT: begin
                    next_st.en[N_SRC-1:PRI_SRCS] = bus.wdata;
                end
                ADDR_PRIO_PRI: begin
                    next_st.prio[PRI_SRCS-1:0] = bus.wdata[PRI_SRCS-1:0];
                end
                ADDR_PRIO_EXT: begin
                    next_st.prio[N_SRC-1:PRI_SRCS] = bus.wdata;
                end
                ADDR_PEND_LO: begin
                    next_st.pend[PEND_SPLIT-1:0] = bus.wdata;
                end
                ADDR_PEND_HI: begin
                    next_st.pend[N_SRC-1:PEND_SPLIT] = bus.wdata[N_SRC-PEND_SPLIT-1:0];
                end
                default: begin
                end
            endcase
        end
        // Long call to the chosen source
        if (take) begin
            if (HW_CLEAR[takeIdx]) begin
                next_st.pend[takeIdx] = 1'b0;
            end
            if (hiFound) begin
                next_st.activeHigh = 1'b1;
            end else begin
                next_st.activeLow = 1'b1;
            end
            next_st.callStart  = 1'b1;
            next_st.callHigh   = hiFound;
            next_st.callVector = VEC_W'(VEC_BASE + VEC_W'(32'(takeIdx) * 32'(VEC_STEP)));
        end
        // Return closes the innermost routine; blockOne marks the instruction after it
        if (core.instrEnd) begin
            next_st.blockOne = core.retiEnd;
            if (core.retiEnd) begin
                if (st.activeHigh) begin
                    next_st.activeHigh = 1'b0;
                end else begin
                    next_st.activeLow = 1'b0;
                end
            end
        end
        // Hardware events win over any clear in the same cycle
        next_st.pend = next_st.pend | evt;
        // Request is resampled every clock
        next_st.irqRequest = |elig;
        // Register reads
        if (bus.rd) begin
            case (bus.addr)
                ADDR_MASK_PRI: next_st.rdata = {st.gate, st.en[PRI_SRCS-1:0]};
                ADDR_MASK_EXT: next_st.rdata = st.en[N_SRC-1:PRI_SRCS];
                ADDR_PRIO_PRI: next_st.rdata = {1'b0, st.prio[PRI_SRCS-1:0]};
                ADDR_PRIO_EXT: next_st.rdata = st.prio[N_SRC-1:PRI_SRCS];
                ADDR_PEND_LO:  next_st.rdata = st.pend[PEND_SPLIT-1:0];
                ADDR_PEND_HI:  next_st.rdata = {1'b0, st.pend[N_SRC-1:PEND_SPLIT]};
                ADDR_STATUS:   next_st.rdata = {5'h00, st.blockOne, st.activeHigh, st.activeLow};
                default:       next_st.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // All sources start masked and at low priority
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st            <= '0;
            st.en         <= RST_SRC_BITS;
            st.prio       <= RST_SRC_BITS;
            st.pend       <= RST_SRC_BITS;
            st.extPrev    <= '1;
            st.callVector <= VEC_BASE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register
    assign rdata       = st.rdata;
    assign irqRequest  = st.irqRequest;
    assign inService   = {st.activeHigh, st.activeLow};
    assign call.start  = st.callStart;
    assign call.high   = st.callHigh;
    assign call.vector = st.callVector;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_return;
        core.instrEnd && core.retiEnd;
    endsequence

    sequence s_next_boundary;
        core.instrEnd && !core.retiEnd && (|hiSet || |loSet) && !st.activeHigh && !st.activeLow;
    endsequence

    // Event reaches its flag whatever the enables hold
    a_flag_sets: assert property (|evt |=> ((st.pend & $past(evt)) == $past(evt)))
        else $error("source event did not set its pending flag");

    // Enabled flag with gate open raises the request next cycle
    a_req_raised: assert property (st.gate && |(st.pend & st.en) |=> irqRequest)
        else $error("enabled pending flag raised no request");

    // Closed gate allows no request and no vectoring
    a_gate_blocks: assert property (!st.gate |=> !irqRequest && !call.start)
        else $error("request raised while global gate closed");

    // Vectoring only follows an instruction boundary
    a_call_boundary: assert property (call.start |-> $past(core.instrEnd) && !$past(core.retiEnd))
        else $error("long call without instruction boundary");

    // No eligible flag means no vectoring
    a_idle_no_call: assert property (core.instrEnd && !(|elig) |=> !call.start)
        else $error("vectoring with no enabled pending flag");

    // Self-clearing flag drops as its routine is entered
    a_hw_clear: assert property (take && HW_CLEAR[takeIdx] && !evt[takeIdx]
        |=> !st.pend[$past(takeIdx)])
        else $error("self-clearing flag still set after vectoring");

    // Return holds off one instruction, then re-enters
    a_reenter: assert property (st.blockOne && s_next_boundary |=> call.start)
        else $error("no re-entry after one instruction");

    a_return_gap: assert property (s_return |=> !call.start)
        else $error("re-entry without one instruction between");

    // High routine is never preempted
    a_no_preempt: assert property (call.start |-> !$past(st.activeHigh))
        else $error("high priority routine was preempted");

    // High level wins over low when both wait
    a_high_first: assert property (take && hiFound && loFound |=> call.high && inService[1])
        else $error("low level served before high");

    // Software write to the low pending register sets its flags
    a_soft_set: assert property (bus.wr && bus.addr == ADDR_PEND_LO && !take
        |=> (st.pend[PEND_SPLIT-1:0] & $past(bus.wdata)) == $past(bus.wdata))
        else $error("software write did not set pending flag");

    // Falling edge on either synchronised pin sets its flag
    a_ext0_edge: assert property ($fell(extSync[0]) |=> st.pend[EXT0_IDX])
        else $error("pin 0 edge did not set its pending flag");

    a_ext1_edge: assert property ($fell(extSync[1]) |=> st.pend[EXT1_IDX])
        else $error("pin 1 edge did not set its pending flag");

    // A low routine never interrupts another low routine
    a_low_no_nest: assert property (call.start && !call.high |-> !$past(st.activeLow))
        else $error("low priority routine was preempted by low");

    // Return from a high routine closes it
    a_return_high: assert property (core.instrEnd && core.retiEnd && st.activeHigh
        |=> !st.activeHigh)
        else $error("return left the high routine active");

    // Return from the only low routine closes it
    a_return_low: assert property (core.instrEnd && core.retiEnd && !st.activeHigh
        && st.activeLow |=> !st.activeLow)
        else $error("return left the low routine active");

    // No enabled flag drops the request
    a_req_drop: assert property (!(|elig) |=> !irqRequest)
        else $error("request raised with no enabled pending flag");

    // Entered routine shows up in service at once
    a_in_service: assert property (call.start |-> (call.high ? inService[1] : inService[0]))
        else $error("entered routine not marked in service");

    // Low level is entered only when no high request waits
    a_pick_low: assert property (take && !hiFound |=> !call.high)
        else $error("low call marked as high level");

endmodule

// >>> ilc_core_model.sv
// Behavioural processor core that retires instructions and runs service routines
module ilc_core_model
    import ilc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] gap,
    input  wire logic       retiReq,
    input  wire ilc_call_t  call,
    output ilc_core_t       core
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] count;
    logic       retiPending;
    logic       boundary;

    // An instruction ends when the count reaches gap, unless a long_call restarts it
    assign boundary = !call.start && (count >= gap);

    // ************************************************************
    // Instruction boundaries
    // ************************************************************
    // One boundary every gap+1 cycles; a long_call restarts the count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count       <= 4'h0;
            retiPending <= 1'b0;
            core        <= '0;
        end else begin
            core.instrEnd <= boundary;
            core.retiEnd  <= boundary && retiPending;
            retiPending   <= (retiPending && !boundary) || retiReq;
            if (call.start || boundary) begin
                count <= 4'h0;
            end else begin
                count <= count + 4'h1;
            end
        end
    end
endmodule

// >>> tb_two_level_interrupt_controller.sv
// Self-checking testbench of the two-level interrupt controller
module tb_two_level_interrupt_controller;
    import ilc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic             clk;
    logic             reset;
    ilc_bus_t         bus;
    logic [DW-1:0]    rdata;
    logic [N_SRC-1:0] srcEvent;
    logic [N_EXT-1:0] extIrq_n;
    ilc_core_t        core;
    ilc_call_t        call;
    logic             irqRequest;
    logic [1:0]       inService;
    logic [3:0]       gap;
    logic             retiReq;
    int               failures;
    int               n_tests;
    int               nCalls;
    int               nb;
    logic [VEC_W-1:0] lastVec;
    logic             lastHigh;

    // ************************************************************
    // Instances
    // ************************************************************
    ilc_controller #(.HW_CLEAR(HW_CLEAR_SRCS)) u_ilc_controller (
        .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .srcEvent(srcEvent),
        .extIrq_n(extIrq_n), .core(core), .call(call), .irqRequest(irqRequest),
        .inService(inService)
    );

    ilc_core_model u_ilc_core_model (
        .clk(clk), .reset(reset), .gap(gap), .retiReq(retiReq), .call(call), .core(core)
    );

    // Clock of 50 ns period
    always #25 clk = ~clk;

    // Records every long_call seen by the core
    always @(negedge clk) begin
        if (call.start === 1'b1) begin
            nCalls++;
            lastVec  = call.vector;
            lastHigh = call.high;
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic finish_test();
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd   <= 1'b0;
        @(negedge clk);
        chk(16'(rdata), 16'(exp));
    endtask

    task automatic ev(input logic [N_SRC-1:0] m);
        @(posedge clk);
        srcEvent <= m;
        @(posedge clk);
        srcEvent <= '0;
    endtask

    task automatic wait_call(input logic [VEC_W-1:0] v, input logic h);
        int n0;
        n0 = nCalls;
        for (int i = 0; i < 60 && nCalls == n0; i++) begin
            @(posedge clk);
        end
        if (nCalls == n0) begin
            failures++;
            finish_test();
        end else begin
            chk(lastVec, v);
            chk(16'(lastHigh), 16'(h));
        end
    endtask

    task automatic no_call();
        int n0;
        n0 = nCalls;
        repeat (30) @(posedge clk);
        chk(16'(nCalls - n0), 16'h0000);
    endtask

    // Issues a return; nb counts boundaries until the next call, -1 if none
    task automatic do_return_from_interrupt(output int n);
        int i;
        int b;
        n = -1;
        b = 0;
        @(posedge clk);
        retiReq <= 1'b1;
        @(posedge clk);
        retiReq <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (core.instrEnd === 1'b1 && core.retiEnd === 1'b1) break;
        end
        if (i == 40) begin
            failures++;
            finish_test();
        end else begin
            // Boundaries completed after the return before the long_call shows
            for (i = 0; i < 40 && n == -1; i++) begin
                @(negedge clk);
                if (call.start === 1'b1) n = b;
                if (core.instrEnd === 1'b1) b++;
            end
            @(posedge clk);
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        clk = 0; reset = 1; bus = '0; srcEvent = '0; extIrq_n = 2'h3;
        gap = 4'h3; retiReq = 0; failures = 0; n_tests = 0; nCalls = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) rd(AW'(a), 8'h00);
        // External pin edge sets its flag with everything masked
        @(posedge clk);
        extIrq_n <= 2'h2;
        repeat (6) @(posedge clk);
        extIrq_n <= 2'h3;
        rd(ADDR_PEND_LO, 8'h01);
        chk(16'(irqRequest), 16'h0000);
        wr(ADDR_PEND_LO, 8'h00);
        ev(15'h0010);
        rd(ADDR_PEND_LO, 8'h10);
        wr(ADDR_MASK_PRI, 8'h10);
        no_call();
        chk(16'(irqRequest), 16'h0000);
        wr(ADDR_MASK_PRI, 8'h90);
        wait_call(16'h0023, 1'b0);
        chk(16'(irqRequest), 16'h0001);
        rd(ADDR_STATUS, 8'h01);
        rd(ADDR_PEND_LO, 8'h10);
        do_return_from_interrupt(nb);
        chk(16'(nb), 16'h0001);
        chk(lastVec, 16'h0023);
        wr(ADDR_PEND_LO, 8'h00);
        do_return_from_interrupt(nb);
        chk(16'(nb), 16'hffff);
        rd(ADDR_STATUS, 8'h00);
        // Self-clearing source
        wr(ADDR_MASK_PRI, 8'h82);
        ev(15'h0002);
        wait_call(16'h000b, 1'b0);
        rd(ADDR_PEND_LO, 8'h00);
        do_return_from_interrupt(nb);
        chk(16'(nb), 16'hffff);
        // Two levels recognised together
        wr(ADDR_PRIO_PRI, 8'h40);
        ev(15'h0048);
        wr(ADDR_MASK_PRI, 8'hc8);
        wait_call(16'h0033, 1'b1);
        no_call();
        wr(ADDR_PEND_LO, 8'h08);
        do_return_from_interrupt(nb);
        chk(16'(nb), 16'h0001);
        chk(lastVec, 16'h001b);
        ev(15'h0040);
        wait_call(16'h0033, 1'b1);
        rd(ADDR_STATUS, 8'h03);
        chk(16'(inService), 16'h0003);
        wr(ADDR_PEND_LO, 8'h00);
        do_return_from_interrupt(nb);
        rd(ADDR_STATUS, 8'h01);
        do_return_from_interrupt(nb);
        rd(ADDR_STATUS, 8'h00);
        // Slow core, software-set flag
        gap <= 4'h9;
        wr(ADDR_MASK_EXT, 8'h04);
        wr(ADDR_PEND_HI, 8'h02);
        wait_call(16'h004b, 1'b0);
        wr(ADDR_PEND_HI, 8'h00);
        do_return_from_interrupt(nb);
        chk(16'(nb), 16'hffff);
        finish_test();
    end
endmodule
